// File: src/cnm_nmt_node.sv
`timescale 1ns/10ps
`include "cnm_map.svh"
module cnm_nmt_node import cnm_pkg::*; #(
  parameter int MS_CYC = `CNM_MS_CYC,
  parameter int INIT_CYC = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [6:0] node_number,
  input wire logic rx_valid,
  input wire cnm_frame_t rx_frame,
  output cnm_tx_t tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic outputs_release,
  output logic outputs_error,
  output logic pdo_enable,
  output logic sdo_enable,
  output logic app_reset,
  output logic irq,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  // ==========================================================
  // Frame decode
  // ==========================================================
  cnm_state_t state_reg, state_next;
  logic [15:0] guard_reg;
  logic [7:0] life_reg;
  logic [15:0] hbt_reg;
  logic [3:0] irq_reg, irq_next, mask_reg;
  logic guard_act_reg, boot_pend_reg, hb_pend_reg, gd_pend_reg;
  logic [7:0] init_cnt_reg;
  logic [31:0] tick_reg, gd_ms_reg, hb_ms_reg;
  logic [10:0] cobid;
  logic [7:0] state_code;
  wire nmt_frame = rx_valid && rx_frame.id == `CNM_NMT_ID && !rx_frame.rtr
                   && rx_frame.dlc == `CNM_NMT_DLC;
  wire for_me = rx_frame.b1 == `CNM_BCAST || rx_frame.b1 == {1'b0, node_number};
  wire cmd_ok = nmt_frame && for_me;
  wire rst_node = cmd_ok && rx_frame.b0 == `CNM_CS_RST_NODE;
  wire rst_comm = cmd_ok && rx_frame.b0 == `CNM_CS_RST_COMM;
  assign cobid = `CNM_EC_BASE + {4'h0, node_number};
  wire guard_req = rx_valid && rx_frame.rtr && rx_frame.id == cobid;
  wire ms_tick = tick_reg == 32'(MS_CYC - 1);
  wire [31:0] life_ms = 32'(guard_reg) * 32'(life_reg);
  wire mon_on = guard_act_reg && guard_reg != 16'h0000 && life_reg != 8'h00;
  wire life_exp = mon_on && ms_tick && gd_ms_reg + 32'h1 >= life_ms;
  wire hb_on = hbt_reg != 16'h0000;
  wire hb_exp = hb_on && ms_tick && hb_ms_reg + 32'h1 >= {16'h0000, hbt_reg};
  wire init_done = state_reg == CNM_INIT && init_cnt_reg == 8'(INIT_CYC - 1);

  // ==========================================================
  // Node state machine
  // ==========================================================
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CNM_INIT: begin
        if (init_done) begin
          state_next = CNM_PREOP;
        end
      end
      CNM_PREOP, CNM_OPER, CNM_STOP: begin
        if (rst_node || rst_comm) begin
          state_next = CNM_INIT;
        end else if (cmd_ok && rx_frame.b0 == `CNM_CS_START) begin
          state_next = CNM_OPER;
        end else if (cmd_ok && rx_frame.b0 == `CNM_CS_STOP) begin
          state_next = CNM_STOP;
        end else if (cmd_ok && rx_frame.b0 == `CNM_CS_PREOP) begin
          state_next = CNM_PREOP;
        end else if (life_exp) begin
          state_next = CNM_PREOP;
        end
      end
      default: begin
        state_next = CNM_INIT;
      end
    endcase
  end

  always_comb begin
    case (state_reg)
      CNM_STOP: state_code = `CNM_ST_STOP;
      CNM_OPER: state_code = `CNM_ST_OPER;
      CNM_PREOP: state_code = `CNM_ST_PREOP;
      default: state_code = `CNM_ST_BOOT;
    endcase
  end

  assign outputs_release = state_reg == CNM_OPER;
  assign outputs_error = state_reg == CNM_STOP;
  assign pdo_enable = state_reg == CNM_OPER;
  assign sdo_enable = state_reg == CNM_PREOP || state_reg == CNM_OPER;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= CNM_INIT;
      init_cnt_reg <= 8'h00;
      app_reset <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
      init_cnt_reg <= (state_next == CNM_INIT && !init_done) ? init_cnt_reg + 8'h01 : 8'h00;
      app_reset <= rst_node ? 1'b1 : (init_done ? 1'b0 : app_reset);
    end
  end

  // ==========================================================
  // Guard and heartbeat timers
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_reg <= 32'h0;
      gd_ms_reg <= 32'h0;
      hb_ms_reg <= 32'h0;
      guard_act_reg <= 1'b0;
    end else if (clk_en) begin
      tick_reg <= ms_tick ? 32'h0 : tick_reg + 32'h1;
      if (rst_node || rst_comm) begin
        guard_act_reg <= 1'b0;
      end else if (guard_req) begin
        guard_act_reg <= 1'b1;
      end
      if (guard_req || life_exp || !mon_on) begin
        gd_ms_reg <= 32'h0;
      end else if (ms_tick) begin
        gd_ms_reg <= gd_ms_reg + 32'h1;
      end
      if (hb_exp || !hb_on) begin
        hb_ms_reg <= 32'h0;
      end else if (ms_tick) begin
        hb_ms_reg <= hb_ms_reg + 32'h1;
      end
    end
  end

  // ==========================================================
  // Transmit arbitration
  // ==========================================================
  always_comb begin
    tx_valid = boot_pend_reg || gd_pend_reg || hb_pend_reg;
    tx_frame.id = cobid;
    tx_frame.data = boot_pend_reg ? `CNM_ST_BOOT : state_code;
  end
  wire tx_fire = tx_valid && tx_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_pend_reg <= 1'b0;
      gd_pend_reg <= 1'b0;
      hb_pend_reg <= 1'b0;
    end else if (clk_en) begin
      boot_pend_reg <= init_done || (boot_pend_reg && !tx_fire);
      gd_pend_reg <= (guard_req && state_reg != CNM_INIT)
                     || (gd_pend_reg && !(tx_fire && !boot_pend_reg));
      hb_pend_reg <= (hb_exp && state_reg != CNM_INIT)
                     || (hb_pend_reg && !(tx_fire && !boot_pend_reg && !gd_pend_reg));
    end
  end

  // ==========================================================
  // Register slave
  // ==========================================================
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  assign s_axil_awready = !aw_hold_reg && !s_axil_bvalid;
  assign s_axil_wready = !w_hold_reg && !s_axil_bvalid;
  wire aw_have = aw_hold_reg || s_axil_awvalid;
  wire w_have = w_hold_reg || s_axil_wvalid;
  wire [7:0] wa = aw_hold_reg ? awaddr_reg : s_axil_awaddr;
  wire [31:0] wd = w_hold_reg ? wdata_reg : s_axil_wdata;
  wire [3:0] ws = w_hold_reg ? wstrb_reg : s_axil_wstrb;
  wire wr_go = aw_have && w_have && !s_axil_bvalid;
  wire wr_ok = wa == `CNM_A_GUARD || wa == `CNM_A_LIFE || wa == `CNM_A_HBT
               || wa == `CNM_A_IRQ || wa == `CNM_A_MASK || wa == `CNM_A_CTRL
               || wa == `CNM_A_STAT || wa == `CNM_A_COBID;
  wire irq_clr_we = wr_go && wa == `CNM_A_IRQ && ws[0];
  wire [3:0] irq_ev = {life_exp, guard_req, cmd_ok, init_done};
  assign irq_next = (irq_reg & ~(irq_clr_we ? wd[3:0] : 4'h0)) | irq_ev;
  assign irq = |(irq_reg & mask_reg);
  wire comm_rst = rst_node || rst_comm;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `CNM_RESP_OK;
      guard_reg <= 16'h0000;
      life_reg <= 8'h00;
      hbt_reg <= 16'h0000;
      irq_reg <= 4'h0;
      mask_reg <= 4'h0;
    end else if (clk_en) begin
      irq_reg <= irq_next;
      if (s_axil_awvalid && s_axil_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axil_wdata;
        wstrb_reg <= s_axil_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_ok ? `CNM_RESP_OK : `CNM_RESP_DEC;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
      if (comm_rst) begin
        guard_reg <= 16'h0000;
        life_reg <= 8'h00;
        hbt_reg <= 16'h0000;
      end else if (wr_go) begin
        if (wa == `CNM_A_GUARD && ws[0]) guard_reg[7:0] <= wd[7:0];
        if (wa == `CNM_A_GUARD && ws[1]) guard_reg[15:8] <= wd[15:8];
        if (wa == `CNM_A_LIFE && ws[0]) life_reg <= wd[7:0];
        if (wa == `CNM_A_HBT && ws[0]) hbt_reg[7:0] <= wd[7:0];
        if (wa == `CNM_A_HBT && ws[1]) hbt_reg[15:8] <= wd[15:8];
      end
      if (wr_go && wa == `CNM_A_MASK && ws[0]) begin
        mask_reg <= wd[3:0];
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (s_axil_araddr)
      `CNM_A_CTRL: rd_mux = {25'h0, node_number};
      `CNM_A_STAT: rd_mux = {22'h0, guard_act_reg, hb_on, state_code};
      `CNM_A_GUARD: rd_mux = {16'h0, guard_reg};
      `CNM_A_LIFE: rd_mux = {24'h0, life_reg};
      `CNM_A_HBT: rd_mux = {16'h0, hbt_reg};
      `CNM_A_IRQ: rd_mux = {28'h0, irq_reg};
      `CNM_A_MASK: rd_mux = {28'h0, mask_reg};
      `CNM_A_COBID: rd_mux = {21'h0, cobid};
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_hit = s_axil_araddr <= `CNM_A_COBID && s_axil_araddr[1:0] == 2'h0;
  assign s_axil_arready = !s_axil_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0;
      s_axil_rresp <= `CNM_RESP_OK;
    end else if (clk_en) begin
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_mux;
        s_axil_rresp <= rd_hit ? `CNM_RESP_OK : `CNM_RESP_DEC;
      end else if (s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_start_oper: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cmd_ok && rx_frame.b0 == `CNM_CS_START && state_reg != CNM_INIT
    |=> state_reg == CNM_OPER) else $error("start command not taken");
  a_stop_state: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cmd_ok && rx_frame.b0 == `CNM_CS_STOP && state_reg != CNM_INIT
    |=> outputs_error && !sdo_enable && !pdo_enable) else $error("stop not applied");
  a_preop_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cmd_ok && rx_frame.b0 == `CNM_CS_PREOP && state_reg != CNM_INIT
    |=> sdo_enable && !pdo_enable) else $error("pre-op command not taken");
  a_other_node: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && nmt_frame && !for_me && !life_exp |=> $stable(state_reg))
    else $error("foreign command changed state");
  a_boot_msg: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && init_done |=> state_reg == CNM_PREOP && tx_valid && tx_frame.data == 8'h00)
    else $error("boot-up message missing");
  a_reset_init: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && (rst_node || rst_comm) && state_reg != CNM_INIT
    |=> state_reg == CNM_INIT && hbt_reg == 16'h0000) else $error("reset not done");
  a_guard_off: assert property (@(posedge aclk) disable iff (!aresetn)
    guard_reg == 16'h0000 || life_reg == 8'h00 |-> !life_exp)
    else $error("expiry while monitoring off");
  a_guard_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !guard_act_reg |-> !life_exp) else $error("expiry before first request");
  a_hb_id: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid |-> tx_frame.id == 11'h700 + {4'h0, node_number}) else $error("bad reply id");
  c_oper: cover property (@(posedge aclk) state_reg == CNM_PREOP ##1 state_reg == CNM_OPER);
  c_life: cover property (@(posedge aclk) life_exp);
  c_hb: cover property (@(posedge aclk) hb_pend_reg && tx_fire);
endmodule

// File: src/cnm_map.svh
`ifndef CNM_MAP_SVH
`define CNM_MAP_SVH
`define CNM_NMT_ID 11'h000
`define CNM_NMT_DLC 4'h2
`define CNM_BCAST 8'h00
`define CNM_CS_START 8'h01
`define CNM_CS_STOP 8'h02
`define CNM_CS_PREOP 8'h80
`define CNM_CS_RST_NODE 8'h81
`define CNM_CS_RST_COMM 8'h82
`define CNM_EC_BASE 11'h700
`define CNM_ST_BOOT 8'h00
`define CNM_ST_STOP 8'h04
`define CNM_ST_OPER 8'h05
`define CNM_ST_PREOP 8'h7F
`define CNM_MS_US 32'd125
`define CNM_MS_CYC 32'd125000
`define CNM_INIT_CYC 8'h10
`define CNM_A_CTRL 8'h00
`define CNM_A_STAT 8'h04
`define CNM_A_GUARD 8'h08
`define CNM_A_LIFE 8'h0C
`define CNM_A_HBT 8'h10
`define CNM_A_IRQ 8'h14
`define CNM_A_MASK 8'h18
`define CNM_A_COBID 8'h1C
`define CNM_RESP_OK 2'h0
`define CNM_RESP_DEC 2'h3
`endif

// File: src/cnm_pkg.sv
package cnm_pkg;
  typedef enum logic [2:0] {CNM_INIT, CNM_PREOP, CNM_OPER, CNM_STOP} cnm_state_t;
  typedef struct packed {
    logic [10:0] id;
    logic rtr;
    logic [3:0] dlc;
    logic [7:0] b0;
    logic [7:0] b1;
  } cnm_frame_t;
  typedef struct packed {
    logic [10:0] id;
    logic [7:0] data;
  } cnm_tx_t;
endpackage

// File: verification/cnm_master_model.sv
`timescale 1ns/10ps
module cnm_master_model import cnm_pkg::*; (
  input wire logic aclk,
  input wire logic stall,
  output logic rx_valid,
  output cnm_frame_t rx_frame,
  input wire cnm_tx_t tx_frame,
  input wire logic tx_valid,
  output logic tx_ready
);
  cnm_tx_t got_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  assign tx_ready = ~stall;
  // ==========================================================
  // Frames taken from the node, kept in order for the bench.
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_frame);
    end
  end
  // ==========================================================
  // One frame lasts one cycle; afterwards the lines show the inverse.
  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
                      input logic [7:0] cs, input logic [7:0] node);
    cnm_frame_t f;
    f = '{id: id, rtr: rtr, dlc: dlc, b0: cs, b1: node};
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule

// File: verification/cnm_nmt_node_tb.sv
`timescale 1ns/10ps
`include "cnm_map.svh"
module cnm_nmt_node_tb import cnm_pkg::*; ();
  localparam int MS = 10;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, stall = 1'b0;
  logic [6:0] node_number = 7'h01;
  logic rx_valid, tx_valid, tx_ready, outputs_release, outputs_error, pdo_enable;
  logic sdo_enable, app_reset, irq;
  cnm_frame_t rx_frame;
  cnm_tx_t tx_frame;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [31:0] d;
  logic [1:0] r;
  int seed = 32'h09a33c58;
  int mismatches = 0, comparisons = 0, cycles = 0, exp_code = 0;
  localparam logic [7:0] CS_SEQ [4] = '{8'h01, 8'h02, 8'h80, 8'h01};
  always #4 aclk = ~aclk;
  cnm_nmt_node #(.MS_CYC(MS), .INIT_CYC(16)) cnm_nmt_node_inst (
    .aclk, .aresetn, .clk_en, .node_number, .rx_valid, .rx_frame, .tx_frame, .tx_valid,
    .tx_ready, .outputs_release, .outputs_error, .pdo_enable, .sdo_enable, .app_reset, .irq,
    .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
    .s_axil_rvalid, .s_axil_rready);
  cnm_master_model cnm_master_model_inst (
    .aclk, .stall, .rx_valid, .rx_frame, .tx_frame, .tx_valid, .tx_ready);
  // ==========================================================
  // Comparison, verdict and hang guard.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    stall <= ($random(seed) % 3) == 0;
    if (cycles == 8000) begin
      mismatches++;
      finish_test();
    end
  end
  // ==========================================================
  // Bus master: handshakes are judged on the values standing at each rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd);
    logic bt;
    bt = 1'b0;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= wd;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (!bt) begin
      @(posedge aclk);
      bt = s_axil_bvalid;
      if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
    end
    s_axil_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic rt;
    rt = 1'b0;
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    while (!rt) begin
      @(posedge aclk);
      rt = s_axil_rvalid;
      d = s_axil_rdata;
      r = s_axil_rresp;
      if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
    end
    s_axil_rready <= 1'b0;
  endtask
  // ==========================================================
  // Reference model of the node state, held as the reported state code.
  task automatic nmt(input logic [7:0] cs, input logic [6:0] node);
    cnm_master_model_inst.send(`CNM_NMT_ID, 1'b0, `CNM_NMT_DLC, cs, {1'b0, node});
    @(posedge aclk);
    if (node == 7'h00 || node == node_number) begin
      case (cs)
        `CNM_CS_START: exp_code = `CNM_ST_OPER;
        `CNM_CS_STOP: exp_code = `CNM_ST_STOP;
        default: exp_code = `CNM_ST_PREOP;
      endcase
    end
  endtask
  task automatic check_outs();
    axi_rd(`CNM_A_STAT);
    check("state code", {24'h0, d[7:0]}, 32'(exp_code));
    check("release", 32'(outputs_release), 32'(exp_code == 5));
    check("error out", 32'(outputs_error), 32'(exp_code == 4));
    check("pdo", 32'(pdo_enable), 32'(exp_code == 5));
    check("sdo", 32'(sdo_enable), 32'(exp_code == 5 || exp_code == 'h7F));
  endtask
  task automatic wait_tx(input logic [7:0] data);
    int n;
    cnm_tx_t f;
    n = 0;
    while (cnm_master_model_inst.got_q.size() == 0 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    f = (n < 200) ? cnm_master_model_inst.got_q.pop_front() : '1;
    check("tx frame", 32'(f), 32'({`CNM_EC_BASE + 11'(node_number), data}));
  endtask
  task automatic guard_req();
    cnm_master_model_inst.send(`CNM_EC_BASE + 11'(node_number), 1'b1, 4'h0, 8'h00, 8'h00);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    node_number = 7'(1 + {$random(seed)} % 63);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("init app reset", 32'(app_reset), 32'h1);
    check("init sdo", 32'(sdo_enable), 32'h0);
    exp_code = `CNM_ST_PREOP;
    wait_tx(`CNM_ST_BOOT);
    check_outs();
    clk_en <= 1'b0;
    nmt(`CNM_CS_START, 7'h00);
    repeat (20) @(posedge aclk);
    clk_en <= 1'b1;
    exp_code = `CNM_ST_PREOP;
    check_outs();
    axi_rd(`CNM_A_COBID);
    check("reply id", d, 32'(`CNM_EC_BASE + 11'(node_number)));
    axi_rd(8'h20);
    check("unmapped", {30'h0, r}, 32'(`CNM_RESP_DEC));
    cnm_master_model_inst.send(`CNM_NMT_ID, 1'b0, 4'h3, `CNM_CS_START, 8'h00);
    check_outs();
    nmt(`CNM_CS_START, node_number | 7'h40);
    check_outs();
    foreach (CS_SEQ[i]) begin
      nmt(CS_SEQ[i], i[0] ? node_number : 7'h00);
      check_outs();
    end
    axi_wr(`CNM_A_GUARD, 32'h2);
    axi_wr(`CNM_A_LIFE, 32'h2);
    axi_rd(`CNM_A_STAT);
    check("guard idle", 32'(d[9]), 32'h0);
    repeat (3) begin
      guard_req();
      wait_tx(`CNM_ST_OPER);
      repeat (MS) @(posedge aclk);
    end
    check_outs();
    axi_rd(`CNM_A_STAT);
    check("guard on", 32'(d[9]), 32'h1);
    repeat (5 * MS) @(posedge aclk);
    exp_code = `CNM_ST_PREOP;
    check_outs();
    axi_wr(`CNM_A_GUARD, 32'h0);
    nmt(`CNM_CS_START, 7'h00);
    repeat (6 * MS) @(posedge aclk);
    check_outs();
    axi_wr(`CNM_A_IRQ, 32'hF);
    axi_wr(`CNM_A_MASK, 32'h2);
    check("irq clear", 32'(irq), 32'h0);
    nmt(`CNM_CS_PREOP, node_number);
    check("irq set", 32'(irq), 32'h1);
    axi_wr(`CNM_A_IRQ, 32'h2);
    check("irq w1c", 32'(irq), 32'h0);
    axi_wr(`CNM_A_HBT, 32'h1);
    repeat (3) wait_tx(`CNM_ST_PREOP);
    axi_wr(`CNM_A_HBT, 32'h0);
    repeat (2 * MS) @(posedge aclk);
    cnm_master_model_inst.got_q.delete();
    axi_wr(`CNM_A_GUARD, 32'h3);
    nmt(`CNM_CS_RST_COMM, node_number);
    check("comm app reset", 32'(app_reset), 32'h0);
    wait_tx(`CNM_ST_BOOT);
    axi_rd(`CNM_A_GUARD);
    check("guard default", d, 32'h0);
    nmt(`CNM_CS_RST_NODE, 7'h00);
    check("node app reset", 32'(app_reset), 32'h1);
    wait_tx(`CNM_ST_BOOT);
    check_outs();
    finish_test();
  end
endmodule
